// ---- bench/fap_master_model.sv ----
// fap_master_model: stand-in for the bus masters at the access port.
// assumes one bench process calls send and rest, one request per edge.
`timescale 1ns/100ps
module fap_master_model (
  input  wire logic         sys_clk,
  output fap_pkg::fap_req_t accessReq
);
  // ----------------------------------------------------------------
  // request drive
  // ----------------------------------------------------------------
  initial accessReq = '0;

  // request held until the next call, so back-to-back needs no gap
  task automatic send(input fap_pkg::fap_req_t req);
    @(posedge sys_clk);
    accessReq <= req;
  endtask

  // idle drops the whole request, not only valid
  task automatic rest();
    @(posedge sys_clk);
    accessReq <= '0;
  endtask
endmodule // fap_master_model

// ---- bench/tb.sv ----
// tb: self-checking bench of fap_core with an apb master and a master model.
// assumes no apb wait states while clkEn is high and 3-flop pin syncs.
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                sys_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [2:0]          pins    = 3'h0;
  fap_pkg::fap_req_t   accessReq;
  logic                accessGrant;
  fap_pkg::fap_resp_t  accessResp;
  fap_pkg::fap_erase_t eraseCmd;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [7:0]          paddr   = 8'h00;
  logic [31:0]         pwdata  = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                irq;
  logic [1:0]          lvl     = 2'h0;
  logic                sawRef  = 1'b0;
  logic                expErr;
  int                  errors  = 0;
  int                  n_tests = 0;
  logic                expQ[$];
  logic                gq[$];
  // page and dword boundaries of both guards and the execute-only window
  localparam logic [18:0] HOT [10] = '{19'h01FF8, 19'h02000, 19'h037F8, 19'h03800,
    19'h007F8, 19'h00800, 19'h00808, 19'h00810, 19'h7CFF8, 19'h7D000};
  localparam logic [7:0] REGS [6] = '{fap_pkg::OFS_CTRL, fap_pkg::OFS_GUARD0,
    fap_pkg::OFS_GUARD1, fap_pkg::OFS_XO, fap_pkg::OFS_STAT, fap_pkg::OFS_MASK};

  always #12.5 sys_clk = ~sys_clk;

  fap_master_model fap_master_model_i (.sys_clk(sys_clk), .accessReq(accessReq));

  fap_core fap_core_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1), .debugPin(pins[0]),
    .bootRamPin(pins[1]), .bootLoaderPin(pins[2]), .accessReq(accessReq),
    .accessGrant(accessGrant), .accessResp(accessResp), .eraseCmd(eraseCmd),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
  );

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reference decision, worked out independently of the design
  function automatic logic refused(input fap_pkg::fap_req_t r);
    logic lim;
    logic rd;
    lim = (lvl == fap_pkg::LVL1) && (pins != 3'h0);
    rd  = (r.op == fap_pkg::OP_READ);
    refused = (lvl == fap_pkg::LVL2) && (r.master == fap_pkg::MST_DEBUG);
    case (r.area)
      fap_pkg::AREA_MAIN:
        refused |= lim || (!rd && (r.addr[18:11] inside {[8'h04:8'h06], [8'hFA:8'hFF]}))
          || (r.addr[18:3] inside {[16'h0100:16'h0101]}
          && !(rd && r.master == fap_pkg::MST_FETCH));
      fap_pkg::AREA_SYSMEM: refused |= !rd;
      fap_pkg::AREA_OPTION: refused |= !rd && (lvl == fap_pkg::LVL2);
      fap_pkg::AREA_BACKUP: refused |= lim || (r.op == fap_pkg::OP_ERASE);
      default: refused |= lim;
    endcase
  endfunction

  always @(posedge sys_clk)
  begin
    if (accessReq.valid)
      gq.push_back(accessGrant);
    if (accessResp.valid)
    begin
      if (expQ.size() == 0 || gq.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        expErr = expQ.pop_front();
        chk(accessResp.err, expErr);
        chk(gq.pop_front(), !expErr);
      end
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] v, output logic e);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k == 20)
    begin
      errors++;
      test_done();
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] v;
    logic        e;
    apb(1'b1, a, d, v, e);
    chk(e, ee);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic ee);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, 32'h0, v, e);
    chk(v & m, x);
    chk(e, ee);
  endtask

  // random traffic biased to boundaries, then drain the expectations
  task automatic burst(input int n, input int maxm);
    fap_pkg::fap_req_t r;
    int k;
    for (int i = 0; i < n; i++)
    begin
      r.valid  = 1'b1;
      r.master = fap_pkg::fap_master_t'($urandom_range(maxm, 0));
      r.op     = fap_pkg::fap_op_t'($urandom_range(2, 0));
      r.area   = fap_pkg::fap_area_t'($urandom_range(4, 0));
      r.addr   = ($urandom_range(3, 0) == 0) ? 19'($urandom) : HOT[$urandom_range(9, 0)];
      expQ.push_back(refused(r));
      sawRef |= refused(r);
      fap_master_model_i.send(r);
    end
    fap_master_model_i.rest();
    for (k = 0; k < 8 && expQ.size() != 0; k++)
      @(posedge sys_clk);
    chk(expQ.size(), 32'h0);
    if (expQ.size() != 0)
      test_done();
  endtask

  task automatic erase_seen(input logic [2:0] e);
    int k;
    for (k = 0; k < 4 && eraseCmd == 3'h0; k++)
      @(posedge sys_clk);
    chk(eraseCmd, e);
  endtask

  task automatic set_pins(input logic [2:0] p);
    @(posedge sys_clk);
    pins <= p;
    repeat (5) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hEB77E4E7));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (REGS[i]) rd(REGS[i], 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(8'h1C, 32'h1, 1'b1);
    wr(fap_pkg::OFS_GUARD0, 32'h8006_0004, 1'b0);
    wr(fap_pkg::OFS_GUARD1, 32'h80FF_00FA, 1'b0);
    wr(fap_pkg::OFS_XO, 32'h0101_0100, 1'b0);
    rd(fap_pkg::OFS_GUARD1, 32'h80FF_00FA, 32'hFFFFFFFF, 1'b0);
    burst(60, 3);
    rd(fap_pkg::OFS_STAT, {31'h0, sawRef}, 32'h1, 1'b0);
    chk(irq, 1'b0);
    wr(fap_pkg::OFS_MASK, 32'h1, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk(irq, sawRef);
    wr(fap_pkg::OFS_STAT, 32'h3, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    // level 1 with every restricting boot or debug pin in turn
    wr(fap_pkg::OFS_CTRL, 32'h5, 1'b0);
    lvl = fap_pkg::LVL1;
    rd(fap_pkg::OFS_CTRL, 32'h5, 32'h7, 1'b0);
    burst(30, 2);
    for (int p = 0; p < 3; p++)
    begin
      set_pins(3'(1 << p));
      rd(fap_pkg::OFS_PINS, 32'(1 << p), 32'h7, 1'b0);
      burst(15, 2);
    end
    set_pins(3'h0);
    // regression to level 0, with and without the execute-only erase
    wr(fap_pkg::OFS_CTRL, 32'h0, 1'b0);
    lvl = fap_pkg::LVL0;
    erase_seen(3'b111);
    rd(fap_pkg::OFS_STAT, 32'h2, 32'h2, 1'b0);
    wr(fap_pkg::OFS_CTRL, 32'h1, 1'b0);
    wr(fap_pkg::OFS_CTRL, 32'h0, 1'b0);
    erase_seen(3'b110);
    // level 2 can not be left and ignores the pins
    wr(fap_pkg::OFS_CTRL, 32'h2, 1'b0);
    lvl = fap_pkg::LVL2;
    wr(fap_pkg::OFS_CTRL, 32'h0, 1'b1);
    wr(fap_pkg::OFS_GUARD0, 32'h0, 1'b1);
    rd(fap_pkg::OFS_CTRL, 32'h2, 32'h3, 1'b0);
    set_pins(3'h7);
    burst(50, 3);
    test_done();
  end

  initial
  begin
    #500000;
    errors++;
    test_done();
  end
endmodule // tb

// ---- common/fap_pkg.sv ----
// fap_pkg: constants, register map and carrier types of the flash access guard.
// assumes one 40 MHz clock domain and an APB register port.
package fap_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int FLASH_AW   = 19;
  localparam int PAGE_LSB   = 11;
  localparam int PAGE_W     = 8;
  localparam int PAGE_CNT   = 256;
  localparam int DWORD_LSB  = 3;
  localparam int DWORD_W    = 16;
  localparam int NUM_GUARD  = 2;
  localparam int SYNC_W     = 3;

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GUARD0 = 8'h04;
  localparam logic [7:0] OFS_GUARD1 = 8'h08;
  localparam logic [7:0] OFS_XO     = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  localparam logic [7:0] OFS_PINS   = 8'h18;
  localparam int CTRL_LVL_LSB    = 0;
  localparam int CTRL_XOERASE    = 2;
  localparam int GUARD_START_LSB = 0;
  localparam int GUARD_END_LSB   = 16;
  localparam int GUARD_EN        = 31;
  localparam int XO_START_LSB    = 0;
  localparam int XO_END_LSB      = 16;
  localparam int STAT_REFUSE     = 0;
  localparam int STAT_REGRESS    = 1;
  localparam int STAT_W          = 2;

  // ----------------------------------------------------------------
  // levels and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  LVL0 = 2'h0;
  localparam logic [1:0]  LVL1 = 2'h1;
  localparam logic [1:0]  LVL2 = 2'h2;
  localparam logic [1:0]  RST_LVL   = 2'h0;
  localparam logic [31:0] RST_GUARD = 32'h0000_0000;
  localparam logic [31:0] RST_XO    = 32'h0000_0000;
  localparam logic [1:0]  RST_MASK  = 2'h0;

  typedef enum logic [1:0] {MST_FETCH, MST_DATA, MST_DMA, MST_DEBUG} fap_master_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} fap_op_t;
  typedef enum logic [2:0] {AREA_MAIN, AREA_SYSMEM, AREA_OPTION, AREA_BACKUP,
                            AREA_SECONDARY_SRAM} fap_area_t;

  typedef struct packed {
    logic                valid;
    fap_master_t         master;
    fap_op_t             op;
    fap_area_t           area;
    logic [FLASH_AW-1:0] addr;
  } fap_req_t;

  typedef struct packed {
    logic valid;
    logic err;
  } fap_resp_t;

  typedef struct packed {
    logic backup;
    logic secondary_sram;
    logic execOnly;
  } fap_erase_t;
endpackage

// ---- core/fap_core.sv ----
// fap_core: access decision for flash, option bytes, backup registers and
// secondary sram, plus the readout guard level and its erase side effects.
// assumes memories act only on accessGrant and the boot/debug pins are async.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/100ps

// Contract
// [R1] three guard levels exist and level 0 restricts nothing.
// [R2] at level 1 flash is closed while debug is connected or ram or loader boot is chosen.
// [R3] level 2 shuts out debug and ram or loader boot and can never be left; here sys_rst returns level_r to level 0.
// [R4] user code gets read, write and erase of main flash and secondary sram at levels 1 and 2.
// [R5] system memory is read-only, option bytes lock at level 2, backup registers shun debug; here debug is refused there only at levels 1 and 2.
// [R6] a change from level 1 to level 0 erases backup registers and secondary sram; here a sys_rst to level 0 erases nothing.
// [R7] program and erase are refused inside either of two page-granular write guard areas.
// [R8] the execute-only area admits instruction fetches and nothing else.
// [R9] execute-only bounds compare on 64-bit units.
// [R10] an option bit selects whether the execute-only area is erased on regression.
// [R11] flash is one bank of 256 pages of 2 Kbyte used for guard decisions.
// [R12] a refused access gets an error answer and a sticky flag and changes nothing.
module fap_core #(
  parameter int NUM_GUARD = fap_pkg::NUM_GUARD
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               clkEn,
  input  wire logic               debugPin,
  input  wire logic               bootRamPin,
  input  wire logic               bootLoaderPin,
  input  wire fap_pkg::fap_req_t  accessReq,
  output logic                    accessGrant,
  output fap_pkg::fap_resp_t      accessResp,
  output fap_pkg::fap_erase_t     eraseCmd,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    irq
);

  if (NUM_GUARD < 1 || NUM_GUARD > 2)
    $error("fap_core: NUM_GUARD must be 1 or 2");
  // [R11] page map
  if (fap_pkg::PAGE_CNT != (1 << fap_pkg::PAGE_W))
    $error("fap_core: page count does not match page field");

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [fap_pkg::SYNC_W-1:0] pinRaw;
  logic [fap_pkg::SYNC_W-1:0] syncA_r;
  logic [fap_pkg::SYNC_W-1:0] syncB_r;
  logic [fap_pkg::SYNC_W-1:0] syncC_r;
  logic [fap_pkg::SYNC_W-1:0] pins_r;

  assign pinRaw = {bootLoaderPin, bootRamPin, debugPin};

  for (genvar i = 0; i < fap_pkg::SYNC_W; i++)
  begin : g_sync
    // change counts only once two late stages agree
    always_ff @(posedge sys_clk)
    begin
      if (sys_rst)
      begin
        syncA_r[i] <= 1'b0;
        syncB_r[i] <= 1'b0;
        syncC_r[i] <= 1'b0;
        pins_r[i]  <= 1'b0;
      end
      else if (clkEn)
      begin
        syncA_r[i] <= pinRaw[i];
        syncB_r[i] <= syncA_r[i];
        syncC_r[i] <= syncB_r[i];
        if (syncB_r[i] == syncC_r[i])
          pins_r[i] <= syncC_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]                 level_r;
  logic                       xoErase_r;
  logic [31:0]                guard_r [NUM_GUARD];
  logic [31:0]                xo_r;
  logic [fap_pkg::STAT_W-1:0] stat_r;
  logic [fap_pkg::STAT_W-1:0] mask_r;
  logic [fap_pkg::STAT_W-1:0] statSet;
  logic [1:0]                 levelWr;
  logic [1:0]                 level_nxt;
  logic                       apbAcc;
  logic                       apbWr;
  logic                       optLocked;
  logic                       regress;
  logic                       mapped;
  logic                       wrLocked;

  assign apbAcc    = psel && penable && clkEn;
  assign apbWr     = apbAcc && pwrite && !wrLocked;
  assign levelWr   = pwdata[fap_pkg::CTRL_LVL_LSB +: 2];
  // option bytes are read-only once at level 2
  assign optLocked = (level_r == fap_pkg::LVL2);
  assign mapped    = (paddr == fap_pkg::OFS_CTRL) || (paddr == fap_pkg::OFS_GUARD0) ||
                     (paddr == fap_pkg::OFS_GUARD1 && NUM_GUARD > 1) ||
                     (paddr == fap_pkg::OFS_XO) || (paddr == fap_pkg::OFS_STAT) ||
                     (paddr == fap_pkg::OFS_MASK) || (paddr == fap_pkg::OFS_PINS);
  assign wrLocked  = optLocked && (paddr == fap_pkg::OFS_CTRL ||
                     paddr == fap_pkg::OFS_GUARD0 || paddr == fap_pkg::OFS_GUARD1 ||
                     paddr == fap_pkg::OFS_XO);

  // [R1] three levels, odd codes count as level 1
  always_comb
  begin
    level_nxt = level_r;
    if (apbWr && paddr == fap_pkg::OFS_CTRL)
    begin
      if (levelWr == fap_pkg::LVL0)
        level_nxt = fap_pkg::LVL0;
      else if (levelWr == fap_pkg::LVL2)
        level_nxt = fap_pkg::LVL2;
      else
        level_nxt = fap_pkg::LVL1;
    end
  end

  // [R6] regression from level 1 to 0
  assign regress = (level_r == fap_pkg::LVL1) && (level_nxt == fap_pkg::LVL0);

  // [R3] level 2 write path is locked, so it sticks
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      level_r   <= fap_pkg::RST_LVL;
      xoErase_r <= 1'b0;
      xo_r      <= fap_pkg::RST_XO;
    end
    else if (clkEn)
    begin
      level_r <= level_nxt;
      if (apbWr && paddr == fap_pkg::OFS_CTRL)
        xoErase_r <= pwdata[fap_pkg::CTRL_XOERASE];
      if (apbWr && paddr == fap_pkg::OFS_XO)
        xo_r <= pwdata;
    end
  end

  for (genvar g = 0; g < NUM_GUARD; g++)
  begin : g_guardReg
    always_ff @(posedge sys_clk)
    begin
      if (sys_rst)
        guard_r[g] <= fap_pkg::RST_GUARD;
      else if (clkEn && apbWr && paddr == fap_pkg::OFS_GUARD0 + 8'(4 * g))
        guard_r[g] <= pwdata;
    end
  end

  // [R6] erase pulses, one cycle
  // [R10] exec-only erase follows its option bit
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      eraseCmd <= '0;
    else if (clkEn)
    begin
      eraseCmd.backup   <= regress;
      eraseCmd.secondary_sram    <= regress;
      eraseCmd.execOnly <= regress && xoErase_r;
    end
  end

  // ----------------------------------------------------------------
  // access decision
  // ----------------------------------------------------------------
  logic [NUM_GUARD-1:0]       inGuard;
  logic [fap_pkg::PAGE_W-1:0] page;
  logic [fap_pkg::DWORD_W-1:0] dword;
  logic                       inXo;
  logic                       restricted;
  logic                       isDebug;
  logic                       isRead;
  logic                       allow;

  // [R11] 2 Kbyte pages
  assign page  = accessReq.addr[fap_pkg::PAGE_LSB +: fap_pkg::PAGE_W];
  // [R9] 64-bit compare units
  assign dword = accessReq.addr[fap_pkg::DWORD_LSB +: fap_pkg::DWORD_W];
  assign inXo  = (dword >= xo_r[fap_pkg::XO_START_LSB +: fap_pkg::DWORD_W]) &&
                 (dword <= xo_r[fap_pkg::XO_END_LSB +: fap_pkg::DWORD_W]) &&
                 (accessReq.area == fap_pkg::AREA_MAIN);

  for (genvar g = 0; g < NUM_GUARD; g++)
  begin : g_guardHit
    // [R7] page-granular guard window
    assign inGuard[g] = guard_r[g][fap_pkg::GUARD_EN] &&
                        (page >= guard_r[g][fap_pkg::GUARD_START_LSB +: fap_pkg::PAGE_W]) &&
                        (page <= guard_r[g][fap_pkg::GUARD_END_LSB +: fap_pkg::PAGE_W]);
  end

  assign isDebug = (accessReq.master == fap_pkg::MST_DEBUG);
  assign isRead  = (accessReq.op == fap_pkg::OP_READ);
  // boot pins are ignored at level 2, since those boots are disabled
  // a connected debugger closes flash at level 1 just like a debug master
  assign restricted = isDebug || pins_r[0] || pins_r[1] || pins_r[2];

  always_comb
  begin
    allow = 1'b1;
    // [R3] debug port dead at level 2
    if (level_r == fap_pkg::LVL2 && isDebug)
      allow = 1'b0;
    unique case (accessReq.area)
      fap_pkg::AREA_MAIN, fap_pkg::AREA_SECONDARY_SRAM:
      begin
        // [R2] level 1 closes on debug or odd boot
        // [R4] user access open at levels 1 and 2
        if (level_r == fap_pkg::LVL1 && restricted)
          allow = 1'b0;
      end
      fap_pkg::AREA_SYSMEM:
      begin
        // [R5] system memory never written
        if (!isRead)
          allow = 1'b0;
      end
      fap_pkg::AREA_OPTION:
      begin
        // [R5] option bytes read-only at level 2
        if (optLocked && !isRead)
          allow = 1'b0;
      end
      fap_pkg::AREA_BACKUP:
      begin
        // [R5] backup: no erase, no debug at level 1
        if (accessReq.op == fap_pkg::OP_ERASE)
          allow = 1'b0;
        if (level_r == fap_pkg::LVL1 && restricted)
          allow = 1'b0;
      end
      default:
        allow = 1'b0;
    endcase
    // [R7] guarded pages refuse program and erase
    if (accessReq.area == fap_pkg::AREA_MAIN && !isRead && |inGuard)
      allow = 1'b0;
    // [R8] execute-only admits fetches only
    if (inXo && !(accessReq.master == fap_pkg::MST_FETCH && isRead))
      allow = 1'b0;
  end

  // [R12] memories act only on grant
  assign accessGrant = accessReq.valid && allow && clkEn;

  // [R12] error answer one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      accessResp <= '0;
    else if (clkEn)
    begin
      accessResp.valid <= accessReq.valid;
      accessResp.err   <= accessReq.valid && !allow;
    end
  end

  // ----------------------------------------------------------------
  // status, mask, interrupt
  // ----------------------------------------------------------------
  assign statSet = {regress, accessReq.valid && !allow};

  // set wins over a write-one clear
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      stat_r <= '0;
      mask_r <= fap_pkg::RST_MASK;
    end
    else if (clkEn)
    begin
      if (apbWr && paddr == fap_pkg::OFS_STAT)
        stat_r <= (stat_r & ~pwdata[fap_pkg::STAT_W-1:0]) | statSet;
      else
        stat_r <= stat_r | statSet;
      if (apbWr && paddr == fap_pkg::OFS_MASK)
        mask_r <= pwdata[fap_pkg::STAT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else if (clkEn)
      irq <= |(stat_r & mask_r);
  end

  // ----------------------------------------------------------------
  // apb read path, latched in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      fap_pkg::OFS_CTRL:   rdMux = {29'h0, xoErase_r, level_r};
      fap_pkg::OFS_GUARD0: rdMux = guard_r[0];
      fap_pkg::OFS_GUARD1: rdMux = guard_r[NUM_GUARD-1];
      fap_pkg::OFS_XO:     rdMux = xo_r;
      fap_pkg::OFS_STAT:   rdMux = {30'h0, stat_r};
      fap_pkg::OFS_MASK:   rdMux = {30'h0, mask_r};
      fap_pkg::OFS_PINS:   rdMux = {29'h0, pins_r};
      default:             rdMux = 32'h0000_0000;
    endcase
  end

  // one access cycle; locked option writes answer with an error
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (clkEn && psel && !penable)
    begin
      prdata  <= (mapped && !pwrite) ? rdMux : 32'h0000_0000;
      pslverr <= !mapped || (pwrite && wrLocked);
    end
  end

  assign pready = apbAcc;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LVL0_OPEN: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
    (level_r == fap_pkg::LVL0 && clkEn && accessReq.valid && isRead && !inXo &&
     accessReq.area == fap_pkg::AREA_MAIN) |-> accessGrant)
    else $error("level 0 read of main flash refused");

  AST_LVL1_CLOSED: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
    (level_r == fap_pkg::LVL1 && restricted && accessReq.area == fap_pkg::AREA_MAIN)
    |-> !accessGrant)
    else $error("level 1 restricted access granted");

  AST_LVL2_STICKS: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
    (level_r == fap_pkg::LVL2) |=> (level_r == fap_pkg::LVL2) [*3])
    else $error("level 2 was left");

  AST_USER_OPEN: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
    (level_r != fap_pkg::LVL0 && !restricted && clkEn && accessReq.valid && !inXo &&
     accessReq.area == fap_pkg::AREA_SECONDARY_SRAM) |-> accessGrant)
    else $error("user access to secondary sram refused");

  AST_SYSMEM_RO: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
    (accessReq.area == fap_pkg::AREA_SYSMEM && !isRead) |-> !accessGrant)
    else $error("system memory write granted");

  AST_REGRESS_ERASE: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
    (clkEn && regress) |=> (eraseCmd.backup && eraseCmd.secondary_sram &&
                            eraseCmd.execOnly == $past(xoErase_r)))
    else $error("regression erase not issued");

  AST_GUARD_BLOCK: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R7]
    (accessReq.area == fap_pkg::AREA_MAIN && !isRead && |inGuard) |-> !accessGrant)
    else $error("guarded page programmed");

  AST_XO_FETCH: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
    (inXo && accessReq.master != fap_pkg::MST_FETCH) |-> !accessGrant)
    else $error("execute-only area reached by non-fetch");

  AST_NO_ERASE_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
    (clkEn && !regress) |=> !eraseCmd.execOnly && !eraseCmd.backup)
    else $error("erase without regression");

  AST_REFUSE_ERR: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
    (clkEn && accessReq.valid && !allow) |=> (accessResp.err && stat_r[fap_pkg::STAT_REFUSE]))
    else $error("refused access not answered with error");

endmodule // fap_core
